// File: logic/vectored_interrupt_controller.sv
// Function
// - NMI has top priority, ignores mask
// - Mask set blocks all but NMI
// - Each external line level or falling edge
// - NMI edge sensed, rising or falling selectable
// - Highest priority pending passed first, others wait
// - Every source has its own vector number
// - Vectors 3 to 35, address twice number
// - External lines use vectors 4 to 11
// - Internal sources on 12 to 35, 25/26 reserved
// - Addresses 0 to 5 never given to sources
// - Control bit 2 selects NMI edge
// - Sense bit n sets line n mode
// - Sense 0 requests while input low
// - Sense 1 requests on each falling edge
// - Control, sense, enable registers decoded, read/write
// - Enable bit n gates new line requests
// - CPU masks further requests on acceptance
`timescale 1ns/1ns
module vectored_interrupt_controller (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        nonmaskable_n,
  input  wire logic [7:0]  external_request_lines_n,
  input  wire logic [21:0] internal_requests,
  input  wire logic        cpu_mask,
  input  wire logic        vector_ack,
  output logic             irq_request,
  output logic [5:0]       irq_vector,
  output logic [15:0]      irq_vector_addr
);

  logic [7:0]                 sysctl_r;
  logic [7:0]                 sense_r;
  logic [7:0]                 enable_r;
  logic [7:0]                 ext_prev_r;
  logic [7:0]                 ext_pend_r;
  logic                       nmi_prev_r;
  logic                       nmi_pend_r;
  vic_pkg::offer_state_e      state_r;
  logic                       bus_go;
  logic                       wr_go;
  logic                       nmi_edge;
  logic                       ack_hit;
  logic                       nmi_clr;
  logic [7:0]                 ext_fall;
  logic [7:0]                 ext_level;
  logic [7:0]                 ext_clr;
  logic [vic_pkg::NUM_VEC-1:0] req_map;
  logic                       sel_valid;
  logic [5:0]                 sel_vec;

  // Internal source j to its vector, skipping the reserved pair
  function automatic logic [5:0] int_vec(input int j);
    if (j < vic_pkg::INT_LOW_CNT)
      return vic_pkg::VEC_INT0 + 6'(j);
    return vic_pkg::VEC_INT_HI + 6'(j - vic_pkg::INT_LOW_CNT);
  endfunction

  // Register read mux; unmapped indices read as zero
  function automatic logic [31:0] read_word(input logic [15:0] idx);
    case (idx)
      vic_pkg::SYSCTL_IDX: return {24'h000000, sysctl_r};
      vic_pkg::SENSE_IDX:  return {24'h000000, sense_r};
      vic_pkg::ENABLE_IDX: return {24'h000000, enable_r};
      vic_pkg::STATUS_IDX: return {10'h000, irq_vector, 6'h00, irq_request, nmi_pend_r, ext_pend_r};
      default:             return 32'h00000000;
    endcase
  endfunction

  // Bus handshake: one wait cycle, then the access completes
  assign bus_go = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_go  = avs_write & ~avs_waitrequest & avs_byteenable[0];

  // Waitrequest drops for exactly one cycle per request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  // Read data captured early so it stands at the completing edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= read_word(avs_address);
    end
  end

  // Configuration registers; only byte lane 0 carries data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sysctl_r <= vic_pkg::SYSCTL_RST;
      sense_r  <= vic_pkg::SENSE_RST;
      enable_r <= vic_pkg::ENABLE_RST;
    end else if (wr_go) begin
      case (avs_address)
        vic_pkg::SYSCTL_IDX: sysctl_r <= (avs_writedata[7:0] & ~vic_pkg::SYSCTL_RO) | vic_pkg::SYSCTL_RO;
        vic_pkg::SENSE_IDX:  sense_r  <= avs_writedata[7:0];
        vic_pkg::ENABLE_IDX: enable_r <= avs_writedata[7:0];
        default:             ;
      endcase
    end
  end

  // Pin history for edge detection; idle level of the pins is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nmi_prev_r <= 1'b1;
      ext_prev_r <= 8'hFF;
    end else begin
      nmi_prev_r <= nonmaskable_n;
      ext_prev_r <= external_request_lines_n;
    end
  end

  // NMI edge polarity from the control register
  assign nmi_edge = sysctl_r[vic_pkg::NMI_EDGE_BIT] ? (~nmi_prev_r & nonmaskable_n)
                                                    : (nmi_prev_r & ~nonmaskable_n);

  // Per-line sensing: edge latch or live level, both gated by enable
  assign ext_fall  = ext_prev_r & ~external_request_lines_n & enable_r & sense_r;
  assign ext_level = ~external_request_lines_n & enable_r & ~sense_r;

  // Clearing events for the latches
  assign ack_hit = irq_request & vector_ack;
  assign nmi_clr = ack_hit & (irq_vector == vic_pkg::VEC_NMI);
  always_comb begin
    for (int i = 0; i < vic_pkg::NUM_EXT; i++) begin
      // Software purge: mask set, level mode, line disabled
      ext_clr[i] = (ack_hit & (irq_vector == vic_pkg::VEC_EXT0 + 6'(i)))
                 | (cpu_mask & ~sense_r[i] & ~enable_r[i]);
    end
  end

  // Latches: a new edge wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nmi_pend_r <= 1'b0;
      ext_pend_r <= 8'h00;
    end else begin
      nmi_pend_r <= nmi_edge | (nmi_pend_r & ~nmi_clr);
      ext_pend_r <= ext_fall | (ext_pend_r & ~ext_clr);
    end
  end

  // Request map indexed by vector number; a pending edge survives disable
  always_comb begin
    req_map = '0;
    req_map[vic_pkg::VEC_NMI] = nmi_pend_r;
    if (!cpu_mask) begin
      for (int i = 0; i < vic_pkg::NUM_EXT; i++) begin
        req_map[vic_pkg::VEC_EXT0 + 6'(i)] = ext_level[i] | ext_pend_r[i];
      end
      for (int j = 0; j < vic_pkg::NUM_INT; j++) begin
        req_map[int_vec(j)] = internal_requests[j];
      end
    end
  end

  // One distinct vector per source, lowest number first
  vector_select u_select (
    .req_map (req_map),
    .valid   (sel_valid),
    .vec     (sel_vec)
  );

  // Offer toward the CPU; frozen until the CPU has latched it so a
  // late higher source cannot swap the vector mid-sequence
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r         <= vic_pkg::ST_IDLE;
      irq_request     <= 1'b0;
      irq_vector      <= 6'h00;
      irq_vector_addr <= vic_pkg::RESET_VEC_ADDR;
    end else begin
      case (state_r)
        vic_pkg::ST_IDLE: begin
          if (sel_valid) begin
            state_r         <= vic_pkg::ST_OFFER;
            irq_request     <= 1'b1;
            irq_vector      <= sel_vec;
            irq_vector_addr <= {9'h000, sel_vec, 1'b0};
          end
        end
        vic_pkg::ST_OFFER: begin
          if (vector_ack) begin
            state_r     <= vic_pkg::ST_IDLE;
            irq_request <= 1'b0;
          end
        end
        default: begin
          state_r     <= vic_pkg::ST_IDLE;
          irq_request <= 1'b0;
        end
      endcase
    end
  end

  // Checks

  a_nmi_first: assert property (@(posedge clk) disable iff (rst)
    (state_r == vic_pkg::ST_IDLE) && nmi_pend_r |=> irq_request && (irq_vector == vic_pkg::VEC_NMI))
    else $error("pending NMI not offered first");

  a_mask_blocks: assert property (@(posedge clk) disable iff (rst)
    $rose(irq_request) && $past(cpu_mask) |-> irq_vector == vic_pkg::VEC_NMI)
    else $error("maskable source offered while masked");

  a_level_line0: assert property (@(posedge clk) disable iff (rst)
    (state_r == vic_pkg::ST_IDLE) && !cpu_mask && !nmi_pend_r && enable_r[0] && !sense_r[0]
      && !external_request_lines_n[0] |=> irq_request && (irq_vector == vic_pkg::VEC_EXT0))
    else $error("low level on line 0 not offered as vector 4");

  a_edge_latch: assert property (@(posedge clk) disable iff (rst)
    sense_r[1] && enable_r[1] && external_request_lines_n[1]
      ##1 (!external_request_lines_n[1] && sense_r[1] && enable_r[1]) |=> ext_pend_r[1])
    else $error("falling edge on line 1 not latched");

  a_nmi_edge: assert property (@(posedge clk) disable iff (rst)
    $fell(nonmaskable_n) && !sysctl_r[vic_pkg::NMI_EDGE_BIT]
      && !$past(sysctl_r[vic_pkg::NMI_EDGE_BIT]) |=> nmi_pend_r)
    else $error("NMI falling edge missed");

  a_hold_stable: assert property (@(posedge clk) disable iff (rst)
    irq_request && !vector_ack |=> irq_request && $stable(irq_vector) && $stable(irq_vector_addr))
    else $error("offer changed before acknowledge");

  a_ack_release: assert property (@(posedge clk) disable iff (rst)
    irq_request && vector_ack && (irq_vector == vic_pkg::VEC_NMI) && !nmi_edge
      |=> !nmi_pend_r && !irq_request)
    else $error("NMI latch not cleared by acknowledge");

  a_vector_range: assert property (@(posedge clk) disable iff (rst)
    irq_request |-> irq_vector >= vic_pkg::VEC_NMI && irq_vector <= vic_pkg::VEC_LAST
      && irq_vector != vic_pkg::VEC_RSV0 && irq_vector != vic_pkg::VEC_RSV1
      && irq_vector_addr > vic_pkg::RSV_ADDR_LAST)
    else $error("vector outside the source range");

  a_enable_gate: assert property (@(posedge clk) disable iff (rst)
    !enable_r[2] |=> !$rose(ext_pend_r[2]))
    else $error("disabled line 2 latched a request");

  a_bus_answer: assert property (@(posedge clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one wait cycle");

  // Bus, offer and latch housekeeping checks
  a_write_lands: assert property (@(posedge clk) disable iff (rst)
    wr_go && (avs_address == vic_pkg::SENSE_IDX) |=> sense_r == $past(avs_writedata[7:0]))
    else $error("sense write did not land");

  a_bus_rearms: assert property (@(posedge clk) disable iff (rst)
    bus_go |=> avs_waitrequest)
    else $error("waitrequest stayed low after an access");

  a_offer_drops: assert property (@(posedge clk) disable iff (rst)
    irq_request && vector_ack |=> !irq_request)
    else $error("offer held after acknowledge");

  a_addr_twice: assert property (@(posedge clk) disable iff (rst)
    irq_request |-> irq_vector_addr == {9'h000, irq_vector, 1'b0})
    else $error("vector address not twice the number");

  a_ack_clears_edge: assert property (@(posedge clk) disable iff (rst)
    irq_request && vector_ack && (irq_vector == vic_pkg::VEC_EXT0) && !ext_fall[0]
      |=> !ext_pend_r[0])
    else $error("line 0 latch survived acknowledge");

  // Purge only works with the mask up; software must set it first
  a_purge_clears: assert property (@(posedge clk) disable iff (rst)
    cpu_mask && !sense_r[0] && !enable_r[0] |=> !ext_pend_r[0])
    else $error("line 0 latch not purged");

  c_purge_done: cover property (@(posedge clk) disable iff (rst)
    cpu_mask && !sense_r[0] && !enable_r[0] && ext_pend_r[0]);

  c_nmi_served: cover property (@(posedge clk) disable iff (rst)
    irq_request && vector_ack && irq_vector == vic_pkg::VEC_NMI);

  c_level_served: cover property (@(posedge clk) disable iff (rst)
    irq_request && vector_ack && irq_vector == vic_pkg::VEC_EXT0 && !sense_r[0]);

  c_edge_served: cover property (@(posedge clk) disable iff (rst)
    irq_request && vector_ack && irq_vector == vic_pkg::VEC_EXT0 + 6'h01 && sense_r[1]);

  c_internal_served: cover property (@(posedge clk) disable iff (rst)
    irq_request && vector_ack && irq_vector == vic_pkg::VEC_LAST);

endmodule

// File: include/vic_pkg.sv
package vic_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [15:0] SYSCTL_IDX   = 16'hFFC4;
  localparam logic [15:0] SENSE_IDX    = 16'hFFC6;
  localparam logic [15:0] ENABLE_IDX   = 16'hFFC7;
  localparam logic [15:0] STATUS_IDX   = 16'hFFC8;

  // Values after reset
  localparam logic [7:0]  SYSCTL_RST   = 8'h09;
  localparam logic [7:0]  SYSCTL_RO    = 8'h08;  // Bit 3 is fixed and reads as one
  localparam logic [7:0]  SENSE_RST    = 8'h00;
  localparam logic [7:0]  ENABLE_RST   = 8'h00;
  localparam int          NMI_EDGE_BIT = 2;

  // Vector numbers
  localparam int          NUM_VEC      = 36;
  localparam int          NUM_EXT      = 8;
  localparam int          NUM_INT      = 22;
  localparam int          INT_LOW_CNT  = 13;     // Sources below the reserved pair
  localparam logic [5:0]  VEC_NMI      = 6'h03;
  localparam logic [5:0]  VEC_EXT0     = 6'h04;
  localparam logic [5:0]  VEC_INT0     = 6'h0C;
  localparam logic [5:0]  VEC_RSV0     = 6'h19;
  localparam logic [5:0]  VEC_RSV1     = 6'h1A;
  localparam logic [5:0]  VEC_INT_HI   = 6'h1B;
  localparam logic [5:0]  VEC_LAST     = 6'h23;

  // Vector table layout: two bytes per entry
  localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
  localparam logic [15:0] RSV_ADDR_LAST  = 16'h0005;

  // Offer state toward the CPU
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_OFFER = 1'b1
  } offer_state_e;

endpackage

// File: logic/vector_select.sv
`timescale 1ns/1ns
// Fixed priority pick: the lowest vector number that requests wins
module vector_select (
  input  wire logic [vic_pkg::NUM_VEC-1:0] req_map,
  output logic                             valid,
  output logic [5:0]                       vec
);

  // Walk downward so the last hit, the lowest number, stands
  always_comb begin
    valid = 1'b0;
    vec   = 6'h00;
    for (int i = vic_pkg::NUM_VEC - 1; i >= 0; i--) begin
      if (req_map[i]) begin
        valid = 1'b1;
        vec   = 6'(i);
      end
    end
  end

endmodule

// File: bench/cpu_model.sv
`timescale 1ns/1ns
// Behavioural CPU: acks an offer after a chosen delay, then latches the vector and masks in the same cycle
module cpu_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        irq_request,
  input  wire logic [5:0]  irq_vector,
  input  wire logic [15:0] irq_vector_addr,
  input  wire logic [3:0]  ack_delay,
  input  wire logic        sw_load,
  input  wire logic        sw_mask,
  output logic             vector_ack,
  output logic             cpu_mask,
  output logic [5:0]       got_vec,
  output logic [15:0]      got_addr,
  output logic [7:0]       got_count
);
  logic [3:0] wait_r;

  // The delay stands for the instruction still running when the offer arrives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vector_ack <= 1'b0;
      cpu_mask   <= 1'b1;  // Mask is set out of reset
      wait_r     <= 4'h0;
      got_vec    <= 6'h00;
      got_addr   <= 16'h0000;
      got_count  <= 8'h00;
    end else begin
      if (sw_load) begin
        cpu_mask <= sw_mask;
      end else if (vector_ack) begin
        cpu_mask <= 1'b1;
      end
      if (vector_ack) begin
        vector_ack <= 1'b0;
        got_vec    <= irq_vector;
        got_addr   <= irq_vector_addr;
        got_count  <= got_count + 8'h01;
        wait_r     <= 4'h0;
      end else if (irq_request) begin
        if (wait_r >= ack_delay) begin
          vector_ack <= 1'b1;
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end
    end
  end
endmodule

// File: bench/vectored_interrupt_controller_test.sv
`timescale 1ns/1ns
module vectored_interrupt_controller_test;
  logic clk, rst, rd_v, wr_v, wait_v, nmi_n, ack, mask, sw_load, sw_mask;
  logic [15:0] addr, vaddr, gaddr;
  logic [31:0] wdata, rdata, got;
  logic [7:0]  ext_n, gcnt;
  logic [21:0] intr;
  logic [5:0]  vec, gvec;
  logic [3:0]  dly, be;
  logic        req;
  int          bad_count, total_checks, cyc, j, k;

  vectored_interrupt_controller uut (.clk(clk), .rst(rst), .avs_address(addr), .avs_read(rd_v),
    .avs_write(wr_v), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wait_v), .nonmaskable_n(nmi_n), .external_request_lines_n(ext_n),
    .internal_requests(intr), .cpu_mask(mask), .vector_ack(ack), .irq_request(req),
    .irq_vector(vec), .irq_vector_addr(vaddr));
  cpu_model cpu (.clk(clk), .rst(rst), .irq_request(req), .irq_vector(vec), .irq_vector_addr(vaddr),
    .ack_delay(dly), .sw_load(sw_load), .sw_mask(sw_mask), .vector_ack(ack), .cpu_mask(mask),
    .got_vec(gvec), .got_addr(gaddr), .got_count(gcnt));

  // Clock and a hang limit well above the expected run
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Bus cycle: hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= {24'h000000, d};
    if (w) wr_v <= 1'b1;
    else rd_v <= 1'b1;
    do @(posedge clk); while (wait_v !== 1'b0);
    got = rdata;
    wr_v <= 1'b0;
    rd_v <= 1'b0;
  endtask

  task automatic check_reg(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    total_checks++;
    if (got !== {24'h000000, e}) begin
      bad_count++;
      $display("BAD %0t reg %h read %h want %h", $time, a, got, e);
    end
  endtask

  // Clear the mask as a return from the handler would; the ack delay is redrawn at random, 0 to 7, each time
  task automatic unmask();
    @(posedge clk);
    sw_load <= 1'b1;
    sw_mask <= 1'b0;
    dly <= 4'($urandom % 8);
    @(posedge clk);
    sw_load <= 1'b0;
  endtask

  task automatic check_vec(input logic [5:0] e);
    logic [7:0] n;
    n = gcnt;
    for (int i = 0; i < 60 && gcnt === n; i++) @(posedge clk);
    total_checks++;
    if (gcnt === n || gvec !== e || gaddr !== {9'h000, e, 1'b0}) begin
      bad_count++;
      $display("BAD %0t vector %h addr %h want %h", $time, gvec, gaddr, e);
    end
  endtask

  // Nothing may be offered for a while
  task automatic check_quiet();
    logic [7:0] n;
    n = gcnt;
    repeat (12) @(posedge clk);
    total_checks++;
    if (gcnt !== n || req !== 1'b0) begin
      bad_count++;
      $display("BAD %0t unexpected offer %h", $time, vec);
    end
  endtask

  function automatic logic [5:0] int_vec(input int b);
    return (b < 13) ? 6'(12 + b) : 6'(14 + b);  // Skips the reserved pair
  endfunction

  initial begin
    {rst, sw_mask, nmi_n, ext_n, be} = '1;
    {rd_v, wr_v, sw_load, intr, addr, wdata, dly} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    j = $urandom(73778);
    check_reg(vic_pkg::SYSCTL_IDX, 8'h09);
    check_reg(vic_pkg::SENSE_IDX, 8'h00);
    check_reg(vic_pkg::ENABLE_IDX, 8'h00);
    check_reg(16'h0010, 8'h00);
    check_reg(vic_pkg::STATUS_IDX, 8'h00);
    bus(1'b1, vic_pkg::SENSE_IDX, 8'hA5);
    check_reg(vic_pkg::SENSE_IDX, 8'hA5);
    // A write without byte lane 0 must leave the register alone
    be <= 4'hE;
    bus(1'b1, vic_pkg::SENSE_IDX, 8'h3C);
    be <= 4'hF;
    check_reg(vic_pkg::SENSE_IDX, 8'hA5);
    bus(1'b1, vic_pkg::SENSE_IDX, 8'h00);
    bus(1'b1, vic_pkg::ENABLE_IDX, 8'hFF);
    $display("test registers done");
    // Each line held low in level mode, one at a time
    for (int i = 0; i < 8; i++) begin
      ext_n <= ~(8'h01 << i);
      unmask();
      check_vec(6'(4 + i));
      ext_n <= 8'hFF;
      @(posedge clk);
    end
    ext_n <= 8'hDB;
    unmask();
    check_vec(6'h06);
    ext_n <= 8'hDF;
    unmask();
    check_vec(6'h09);
    ext_n <= 8'hFE;
    check_quiet();
    nmi_n <= 1'b0;
    check_vec(6'h03);
    nmi_n <= 1'b1;
    ext_n <= 8'hFF;
    check_quiet();
    $display("test levels done");
    // Lines 0 and 1 in edge mode pulse together; both latch, served in order
    bus(1'b1, vic_pkg::SENSE_IDX, 8'h03);
    ext_n <= 8'hFC;
    @(posedge clk);
    ext_n <= 8'hFF;
    unmask();
    check_vec(6'h04);
    unmask();
    check_vec(6'h05);
    // Latch line 0 under the mask, then purge it by disable and level mode
    ext_n <= 8'hFE;
    @(posedge clk);
    ext_n <= 8'hFF;
    bus(1'b1, vic_pkg::ENABLE_IDX, 8'hFE);
    bus(1'b1, vic_pkg::SENSE_IDX, 8'h02);
    unmask();
    check_quiet();
    // Disabled lines: a level on line 1 and an edge on line 2 are both ignored
    bus(1'b1, vic_pkg::SENSE_IDX, 8'h04);
    bus(1'b1, vic_pkg::ENABLE_IDX, 8'h00);
    ext_n <= 8'hF9;
    check_quiet();
    ext_n <= 8'hFF;
    $display("test edges done");
    for (int i = 0; i < 8; i++) begin
      j = $urandom % 22;
      k = $urandom % 22;
      intr <= (22'h1 << j) | (22'h1 << k);
      unmask();
      check_vec((int_vec(j) < int_vec(k)) ? int_vec(j) : int_vec(k));
      intr <= 22'h0;
      @(posedge clk);
    end
    // Corner: the last source alone lands on the lowest-priority vector
    intr <= 22'h200000;
    unmask();
    check_vec(6'h23);
    intr <= 22'h0;
    $display("test internal done");
    bus(1'b1, vic_pkg::SYSCTL_IDX, 8'h04);
    check_reg(vic_pkg::SYSCTL_IDX, 8'h0C);
    nmi_n <= 1'b0;
    check_quiet();
    nmi_n <= 1'b1;
    check_vec(6'h03);
    check_quiet();
    $display("test nmi edge done");
    report_and_stop();
  end
endmodule
